//--- rtl/wsc_top.sv
// Watchdog timer with sleep entry and wake-up control, AXI4-Lite registers
// How it works
// - Watchdog time base runs regardless of main oscillator gating.
// - Expiry while running gives a full device reset.
// - Expiry while asleep wakes the device without reset.
// - Fuse watchdog enable bit at zero stops the watchdog while the bit stays zero.
// - Base expiry interval is eighteen milliseconds.
// - Option register can add a prescaler up to 1:128.
// - Kick or sleep clears counter, and prescaler when assigned.
// - Every expiry clears the active-low expiry flag.
// - Sleep clears sleep flag, sets expiry flag, clears watchdog, stops oscillator.
// - I/O drive states freeze during sleep.
// - Watchdog reset never drives the external reset pin.
// - Reset pin in sleep resets; watchdog or enabled interrupt resumes.
// - Only individually enabled interrupts wake, whatever the global enable.
// - After interrupt wake, vector to handler only when global enable set.
// - Sleep instruction requests prefetch of the next instruction.
// - Enabled pending interrupt at sleep wakes immediately.
// - Every wake-up clears the watchdog counter.
// - Crystal modes wait 1024 oscillator periods before resuming.
// - Power-up sets the active-low sleep flag.
// - Interrupt flags set on events regardless of enables.
`timescale 1ns/10ps
`default_nettype none

module wsc_top
	import wsc_pkg::*;
#(
	parameter int unsigned WDT_BASE_CYCLES = wsc_pkg::WSC_WDT_BASE_CYC,
	parameter int unsigned BASE_W = 20,
	parameter int unsigned IO_W = 15,
	parameter logic [7:0] CRYSTAL_MODES = 8'h07
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [15:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [7:0] fuse_word,
	input wire logic watchdog_kick_op,
	input wire logic sleep_op,
	input wire logic external_reset_pin_n,
	input wire logic ext_edge_irq_pin,
	input wire logic port_change_evt,
	input wire logic cmp_change_evt,
	input wire logic [IO_W-1:0] io_drive_in,
	input wire logic [IO_W-1:0] io_oe_in,
	output logic [IO_W-1:0] io_drive_out,
	output logic [IO_W-1:0] io_oe_out,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic core_reset,
	output logic core_run,
	output logic main_osc_run,
	output logic prefetch_req,
	output logic resume_pulse,
	output logic resume_vector,
	output logic expiry_flag_n,
	output logic sleep_flag_n
);
	import wsc_pkg::*;

	localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(WDT_BASE_CYCLES - 1);
	localparam logic [9:0] OST_LAST = 10'(WSC_OST_CYC - 1);

	wsc_state_t state_r;
	wsc_state_t state_nxt;
	logic [7:0] option_r;
	logic [7:0] irq_r;
	logic [7:0] irq_nxt;
	logic [BASE_W-1:0] base_cnt_r;
	logic [7:0] pre_cnt_r;
	logic [7:0] pre_last;
	logic [9:0] ost_cnt_r;
	logic aw_held_r;
	logic w_held_r;
	logic [15:0] aw_addr_r;
	logic [7:0] w_data_r;
	logic w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_fire;
	logic wr_hit;
	logic wr_option;
	logic wr_irq;
	logic ext_pin_d_r;
	logic ext_evt;
	logic [WSC_IRQ_SRCS-1:0] src_evt;
	logic pending;
	logic wdt_on;
	logic owner_wdt;
	logic base_done;
	logic expiry;
	logic wdt_reset;
	logic int_rst;
	logic sleep_take;
	logic wake;
	logic resume_nxt;
	logic crystal;
	logic [IO_W-1:0] io_drive_r;
	logic [IO_W-1:0] io_oe_r;
	logic expiry_flag_n_r;
	logic sleep_flag_n_r;
	logic core_reset_r;
	logic core_run_r;
	logic main_osc_run_r;
	logic prefetch_r;
	logic resume_r;
	logic resume_vector_r;

	// AXI write channel: address and data taken in either order
	assign awready = ~aw_held_r & ~bvalid_r;
	assign wready = ~w_held_r & ~bvalid_r;
	assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
	assign wr_hit = (aw_addr_r == WSC_ADDR_OPTION) | (aw_addr_r == WSC_ADDR_IRQ)
		| (aw_addr_r == WSC_ADDR_CONFIG) | (aw_addr_r == WSC_ADDR_STATUS);
	assign wr_option = wr_fire & w_strb_r & (aw_addr_r == WSC_ADDR_OPTION);
	assign wr_irq = wr_fire & w_strb_r & (aw_addr_r == WSC_ADDR_IRQ);
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 16'h0000;
			w_data_r <= 8'h00;
			w_strb_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= WSC_RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held_r <= 1'b1;
				w_data_r <= wdata[7:0];
				w_strb_r <= wstrb[0]; // Registers live in byte lane 0 only
			end
			if (wr_fire)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? WSC_RESP_OKAY : WSC_RESP_SLVERR;
			end
			else if (bvalid_r && bready)
				bvalid_r <= 1'b0;
		end
	end

	// Read decode; unmapped addresses read zero with an error response
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (araddr)
			WSC_ADDR_OPTION: rd_word = {24'h000000, option_r};
			WSC_ADDR_CONFIG: rd_word = {24'h000000, fuse_word};
			WSC_ADDR_IRQ: rd_word = {24'h000000, irq_r};
			WSC_ADDR_STATUS:
			begin
				rd_word[WSC_STS_EXPIRY_N] = expiry_flag_n_r;
				rd_word[WSC_STS_SLEEP_N] = sleep_flag_n_r;
				rd_word[WSC_STS_OST] = (state_r == WSC_ST_OST);
				rd_word[WSC_STS_ASLEEP] = (state_r == WSC_ST_SLEEP);
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// AXI read channel: one read outstanding, answer on the next edge
	assign arready = ~rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= WSC_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_hit ? WSC_RESP_OKAY : WSC_RESP_SLVERR;
		end
		else if (rvalid_r && rready)
			rvalid_r <= 1'b0;
	end

	// Option register, restored on every internal reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn || int_rst)
			option_r <= WSC_OPTION_RST;
		else if (wr_option)
			option_r <= w_data_r;
	end

	// External edge detect, polarity from the option register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_pin_d_r <= 1'b0;
		else
			ext_pin_d_r <= ext_edge_irq_pin;
	end
	assign ext_evt = option_r[WSC_OPT_EDGE] ? (ext_edge_irq_pin & ~ext_pin_d_r)
		: (~ext_edge_irq_pin & ext_pin_d_r);
	assign src_evt = {cmp_change_evt, port_change_evt, ext_evt};

	// Interrupt control: software write, reset clears enables, events set flags
	always_comb
	begin
		irq_nxt = irq_r;
		if (wr_irq)
			irq_nxt = w_data_r;
		if (int_rst)
		begin
			irq_nxt[WSC_IRQ_GIE] = 1'b0;
			irq_nxt[WSC_IRQ_EN_LO +: WSC_IRQ_SRCS] = '0;
		end
		irq_nxt[WSC_IRQ_FLAG_LO +: WSC_IRQ_SRCS] = irq_nxt[WSC_IRQ_FLAG_LO +: WSC_IRQ_SRCS]
			| src_evt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_r <= WSC_IRQ_RST;
		else
			irq_r <= irq_nxt;
	end

	assign pending = |(irq_r[WSC_IRQ_EN_LO +: WSC_IRQ_SRCS]
		& irq_r[WSC_IRQ_FLAG_LO +: WSC_IRQ_SRCS]);

	assign wdt_on = fuse_word[WSC_CFG_WDT_EN];
	assign owner_wdt = option_r[WSC_OPT_OWNER];
	assign pre_last = owner_wdt ? 8'((8'h01 << option_r[WSC_OPT_PS_HI:0]) - 8'h01) : 8'h00;
	assign base_done = wdt_on & (base_cnt_r == BASE_LAST);
	assign expiry = base_done & (pre_cnt_r == pre_last);

	assign wdt_reset = expiry & (state_r == WSC_ST_RUN);
	assign int_rst = wdt_reset | ~external_reset_pin_n;
	assign sleep_take = (state_r == WSC_ST_RUN) & sleep_op & ~int_rst;
	assign wake = (state_r == WSC_ST_SLEEP) & external_reset_pin_n & (expiry | pending);
	assign crystal = CRYSTAL_MODES[{fuse_word[WSC_CFG_OSC2], fuse_word[WSC_CFG_OSC1],
		fuse_word[WSC_CFG_OSC0]}];

	// free-running time base, never gated by the main oscillator
	always_ff @(posedge aclk)
	begin
		if (!aresetn || int_rst)
			base_cnt_r <= '0;
		else if ((watchdog_kick_op && state_r == WSC_ST_RUN) || sleep_take)
			base_cnt_r <= '0;
		else if (wake)
			base_cnt_r <= '0;
		else if (base_done)
			base_cnt_r <= '0;
		else if (wdt_on)
			base_cnt_r <= BASE_W'(base_cnt_r + 1'b1);
	end

	// Prescaler only cleared by kick, sleep or wake while it serves the watchdog
	always_ff @(posedge aclk)
	begin
		if (!aresetn || int_rst)
			pre_cnt_r <= 8'h00;
		else if (owner_wdt && ((watchdog_kick_op && state_r == WSC_ST_RUN) || sleep_take || wake))
			pre_cnt_r <= 8'h00;
		else if (base_done)
			pre_cnt_r <= expiry ? 8'h00 : 8'(pre_cnt_r + 8'h01);
	end

	// Power state sequencing
	always_comb
	begin
		state_nxt = state_r;
		resume_nxt = 1'b0;
		case (state_r)
			WSC_ST_RUN:
			begin
				if (sleep_take)
				begin
					if (pending)
						resume_nxt = 1'b1;
					else
						state_nxt = WSC_ST_SLEEP;
				end
			end
			WSC_ST_SLEEP:
			begin
				// reset pin restarts, other sources resume
				if (!external_reset_pin_n)
					state_nxt = WSC_ST_RUN;
				else if (wake)
				begin
					if (crystal)
						state_nxt = WSC_ST_OST;
					else
					begin
						state_nxt = WSC_ST_RUN;
						resume_nxt = 1'b1;
					end
				end
			end
			WSC_ST_OST:
			begin
				if (!external_reset_pin_n)
					state_nxt = WSC_ST_RUN;
				else if (ost_cnt_r == OST_LAST)
				begin
					state_nxt = WSC_ST_RUN;
					resume_nxt = 1'b1;
				end
			end
			default: state_nxt = WSC_ST_RUN;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_r <= WSC_ST_RUN;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_r != WSC_ST_OST)
			ost_cnt_r <= 10'h000;
		else
			ost_cnt_r <= 10'(ost_cnt_r + 10'h001);
	end

	// Status flags; expiry wins over sleep in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			expiry_flag_n_r <= 1'b1;
			sleep_flag_n_r <= 1'b1;
		end
		else
		begin
			if (sleep_take)
			begin
				sleep_flag_n_r <= 1'b0;
				expiry_flag_n_r <= 1'b1;
			end
			if (expiry)
				expiry_flag_n_r <= 1'b0;
		end
	end

	// pin states frozen outside run, so sleep keeps the last driven values
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			io_drive_r <= '0;
			io_oe_r <= '0;
		end
		else if (state_r == WSC_ST_RUN && !sleep_take)
		begin
			io_drive_r <= io_drive_in;
			io_oe_r <= io_oe_in;
		end
	end

	// Core-facing controls, all registered
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			core_reset_r <= 1'b0;
			core_run_r <= 1'b1;
			main_osc_run_r <= 1'b1;
			prefetch_r <= 1'b0;
			resume_r <= 1'b0;
			resume_vector_r <= 1'b0;
		end
		else
		begin
			core_reset_r <= int_rst;
			core_run_r <= (state_nxt == WSC_ST_RUN);
			main_osc_run_r <= (state_nxt != WSC_ST_SLEEP);
			prefetch_r <= sleep_take;
			resume_r <= resume_nxt;
			if (resume_nxt)
				resume_vector_r <= irq_r[WSC_IRQ_GIE] & pending;
			else if (int_rst)
				resume_vector_r <= 1'b0;
		end
	end

	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = 1'b0;

	assign io_drive_out = io_drive_r;
	assign io_oe_out = io_oe_r;
	assign core_reset = core_reset_r;
	assign core_run = core_run_r;
	assign main_osc_run = main_osc_run_r;
	assign prefetch_req = prefetch_r;
	assign resume_pulse = resume_r;
	assign resume_vector = resume_vector_r;
	assign expiry_flag_n = expiry_flag_n_r;
	assign sleep_flag_n = sleep_flag_n_r;

endmodule : wsc_top

`default_nettype wire

//--- rtl/wsc_pkg.sv
// Constants and types shared by the watchdog and sleep/wake control block
package wsc_pkg;

	// Clock rate and watchdog base interval
	localparam int unsigned WSC_CLK_HZ = 50_000_000;
	localparam int unsigned WSC_WDT_PERIOD_MS = 18;
	localparam int unsigned WSC_WDT_BASE_CYC = WSC_WDT_PERIOD_MS * (WSC_CLK_HZ / 1000);

	// Oscillator start-up delay, one oscillator period per clock cycle
	localparam int unsigned WSC_OST_TOSC = 1024;
	localparam int unsigned WSC_OST_CYC = WSC_OST_TOSC;

	// Register indices; byte address is four times the index
	localparam logic [15:0] WSC_IDX_OPTION = 16'h0081;
	localparam logic [15:0] WSC_IDX_CONFIG = 16'h2007;
	localparam logic [15:0] WSC_IDX_STATUS = 16'h0003;
	localparam logic [15:0] WSC_IDX_IRQ = 16'h000B;
	localparam logic [15:0] WSC_ADDR_OPTION = {WSC_IDX_OPTION[13:0], 2'b00};
	localparam logic [15:0] WSC_ADDR_CONFIG = {WSC_IDX_CONFIG[13:0], 2'b00};
	localparam logic [15:0] WSC_ADDR_STATUS = {WSC_IDX_STATUS[13:0], 2'b00};
	localparam logic [15:0] WSC_ADDR_IRQ = {WSC_IDX_IRQ[13:0], 2'b00};

	// Reset values
	localparam logic [7:0] WSC_OPTION_RST = 8'hFF;
	localparam logic [7:0] WSC_IRQ_RST = 8'h00;

	// Option register fields
	localparam int unsigned WSC_OPT_EDGE = 6;
	localparam int unsigned WSC_OPT_OWNER = 3;
	localparam int unsigned WSC_OPT_PS_HI = 2;

	// Configuration word fields
	localparam int unsigned WSC_CFG_OSC2 = 4;
	localparam int unsigned WSC_CFG_WDT_EN = 2;
	localparam int unsigned WSC_CFG_OSC1 = 1;
	localparam int unsigned WSC_CFG_OSC0 = 0;

	// Status register fields
	localparam int unsigned WSC_STS_EXPIRY_N = 4;
	localparam int unsigned WSC_STS_SLEEP_N = 3;
	localparam int unsigned WSC_STS_OST = 1;
	localparam int unsigned WSC_STS_ASLEEP = 0;

	// Interrupt control fields
	localparam int unsigned WSC_IRQ_GIE = 7;
	localparam int unsigned WSC_IRQ_EN_LO = 4;
	localparam int unsigned WSC_IRQ_FLAG_LO = 0;
	localparam int unsigned WSC_IRQ_SRCS = 3;

	// AXI responses
	localparam logic [1:0] WSC_RESP_OKAY = 2'b00;
	localparam logic [1:0] WSC_RESP_SLVERR = 2'b10;

	// Power state
	typedef enum logic [2:0] {
		WSC_ST_RUN = 3'b001,
		WSC_ST_SLEEP = 3'b010,
		WSC_ST_OST = 3'b100
	} wsc_state_t;

endpackage : wsc_pkg

//--- test/wsc_top_asserts.sv
// Port-level checker for the watchdog and sleep/wake block, bound to the top
`timescale 1ns/10ps
`default_nettype none
module wsc_chk #(
	parameter int unsigned WDT_BASE_CYCLES = 50
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic watchdog_kick_op,
	input wire logic sleep_op,
	input wire logic external_reset_pin_n,
	input wire logic [14:0] io_drive_out,
	input wire logic [14:0] io_oe_out,
	input wire logic reset_pin_oe,
	input wire logic core_reset,
	input wire logic core_run,
	input wire logic main_osc_run,
	input wire logic prefetch_req,
	input wire logic resume_pulse,
	input wire logic expiry_flag_n,
	input wire logic sleep_flag_n
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	int unsigned age_r;
	logic osc_r;
	// Cycles since any clearing event; clears on extra events, so it can only undercount
	always_ff @(posedge aclk)
	begin
		osc_r <= main_osc_run;
		if (!aresetn || sleep_op || core_reset || watchdog_kick_op || (main_osc_run && !osc_r))
			age_r <= 0;
		else
			age_r <= age_r + 1;
	end
	property p_pin_quiet;
		reset_pin_oe == 1'b0;
	endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("reset pin driven");
	property p_pin_reset;
		!external_reset_pin_n |=> core_reset;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin low gave no reset");
	property p_sleep_flag;
		$fell(sleep_flag_n) |-> $past(sleep_op);
	endproperty
	a_sleep_flag: assert property (p_sleep_flag) else $error("sleep flag fell alone");
	property p_prefetch;
		prefetch_req |-> $past(sleep_op) && !sleep_flag_n;
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("stray prefetch");
	property p_osc_off;
		!main_osc_run |-> !core_run && !sleep_flag_n;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("oscillator off while awake");
	property p_io_hold;
		!core_run && $past(!core_run) |-> $stable(io_drive_out) && $stable(io_oe_out);
	endproperty
	a_io_hold: assert property (p_io_hold) else $error("pins moved while halted");
	property p_expiry_reset;
		$fell(expiry_flag_n) && $past(core_run) |-> core_reset;
	endproperty
	a_expiry_reset: assert property (p_expiry_reset) else $error("expiry without reset");
	property p_wdt_age;
		$fell(expiry_flag_n) |-> age_r >= WDT_BASE_CYCLES - 1;
	endproperty
	a_wdt_age: assert property (p_wdt_age) else $error("watchdog expired early");
	property p_resume_run;
		resume_pulse |-> core_run && main_osc_run;
	endproperty
	a_resume_run: assert property (p_resume_run) else $error("resume while halted");
endmodule : wsc_chk
bind wsc_top wsc_chk #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES)) u_chk (.aclk, .aresetn,
	.watchdog_kick_op, .sleep_op, .external_reset_pin_n, .io_drive_out, .io_oe_out,
	.reset_pin_oe, .core_reset, .core_run, .main_osc_run, .prefetch_req, .resume_pulse,
	.expiry_flag_n, .sleep_flag_n);
`default_nettype wire

//--- test/wsc_core.sv
// Processor core stand-in: instruction strobes and live pin drive
`timescale 1ns/10ps
`default_nettype none
module wsc_core
(
	input wire logic aclk,
	output logic kick,
	output logic slp,
	output logic [14:0] drv,
	output logic [14:0] oe
);
	initial
	begin
		kick = 1'b0;
		slp = 1'b0;
		drv = 15'h0000;
		oe = 15'h0000;
	end
	// Pins keep moving every cycle, so a missing freeze shows
	always @(posedge aclk)
	begin
		drv <= 15'($urandom);
		oe <= 15'($urandom);
	end
	// One-cycle strobe: 0 kick, 1 sleep
	task op(input int k);
		@(posedge aclk);
		if (k == 0) kick <= 1'b1;
		else slp <= 1'b1;
		@(posedge aclk);
		kick <= 1'b0;
		slp <= 1'b0;
	endtask : op
endmodule : wsc_core
`default_nettype wire

//--- test/watchdog_sleep_wake_control_bench.sv
// Self-checking bench for the watchdog and sleep/wake block
`timescale 1ns/10ps
`default_nettype none
module watchdog_sleep_wake_control_bench;
	import wsc_pkg::*;
	localparam int B = 50;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic arready, rvalid, pin_n, kick, slp, core_reset, core_run, main_osc_run;
	logic prefetch_req, resume_pulse, resume_vector, expiry_flag_n, sleep_flag_n;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [7:0] fuse;
	logic [2:0] ev;
	logic [14:0] drv, oe, io_do, io_oeo;
	logic rp_out, rp_oe;
	logic [29:0] iosv;
	int miscompares, cmp_count, cyc, n, n0, rsts, g;
	wsc_top #(.WDT_BASE_CYCLES(B)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .fuse_word(fuse), .watchdog_kick_op(kick), .sleep_op(slp),
		.external_reset_pin_n(pin_n), .ext_edge_irq_pin(ev[0]), .port_change_evt(ev[1]),
		.cmp_change_evt(ev[2]), .io_drive_in(drv), .io_oe_in(oe), .io_drive_out(io_do),
		.io_oe_out(io_oeo), .reset_pin_out(rp_out), .reset_pin_oe(rp_oe), .core_reset,
		.core_run, .main_osc_run, .prefetch_req,
		.resume_pulse, .resume_vector, .expiry_flag_n, .sleep_flag_n);
	wsc_core core (.aclk, .kick, .slp, .drv, .oe);
	always #10 aclk = ~aclk;
	// Hang guard and count of core resets seen
	always @(posedge aclk)
	begin
		cyc++;
		if (core_reset) rsts++;
		if (cyc == 40000) miscompares++;
		if (cyc == 40000) end_sim();
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Write address and data offered together, each dropped once taken
	task wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, v};
		{awvalid, wvalid, bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [15:0] a);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	// Edges until resume (s=0) or core reset (s=1), bounded
	task wt_for(input int s, output int c);
		c = 0;
		while (!(s ? core_reset : resume_pulse) && c < 9000)
		begin
			@(posedge aclk);
			c++;
		end
	endtask : wt_for
	task fire(input int k);
		@(posedge aclk);
		ev[k] <= 1'b1;
		@(posedge aclk);
		ev[k] <= 1'b0;
	endtask : fire
	// Expected expiry interval for option setting i
	function automatic int exp_cyc(input int i);
		return (i < 8) ? B << i : B;
	endfunction : exp_cyc
	task end_sim;
		$display("mismatches=%0d compares=%0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	initial
	begin
		void'($urandom(32'hE9D5));
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ev} = '0;
		{awaddr, araddr, wdata} = '0;
		{miscompares, cmp_count, cyc, rsts} = '0;
		wstrb = 4'hF;
		pin_n = 1'b1;
		fuse = 8'h14 | (8'($urandom) & 8'hE8);
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(WSC_ADDR_OPTION);
		chk(d, 32'h000000FF);
		rd(WSC_ADDR_CONFIG);
		chk(d, {24'h000000, fuse});
		rd(WSC_ADDR_STATUS);
		chk(d, 32'h00000018);
		wr(16'h0100, 8'h00);
		chk(32'(r), 32'(WSC_RESP_SLVERR));
		// Write with byte lane 0 masked must leave the option register alone
		wstrb <= 4'($urandom) & 4'hE;
		wr(WSC_ADDR_OPTION, 8'h00);
		wstrb <= 4'hF;
		chk(32'(r), 32'(WSC_RESP_OKAY));
		rd(WSC_ADDR_OPTION);
		chk(d, 32'h000000FF);
		// Every prescaler ratio, then the prescaler handed away
		for (int i = 0; i < 9; i++)
		begin
			wr(WSC_ADDR_OPTION, (i < 8) ? 8'(8 + i) : 8'h07);
			core.op(0);
			wt_for(1, n);
			chk(32'(n >= exp_cyc(i) && n <= exp_cyc(i) + 3), 32'h1);
			chk(32'({rp_out, rp_oe}), 32'h0);
			rd(WSC_ADDR_STATUS);
			chk(d & 32'h10, 32'h0);
		end
		rd(WSC_ADDR_OPTION);
		chk(d, 32'h000000FF);
		wr(WSC_ADDR_OPTION, 8'h00);
		n0 = rsts;
		// Kick first: the count since the last reset may already be near expiry
		repeat (20)
		begin
			core.op(0);
			repeat ($urandom_range(B - 8)) @(posedge aclk);
		end
		chk(32'(rsts - n0), 32'h0);
		fuse <= fuse & 8'hFB;
		core.op(0);
		repeat (3 * B) @(posedge aclk);
		chk(32'(rsts - n0), 32'h0);
		fuse <= fuse | 8'h04;
		core.op(0);
		repeat (B / 2) @(posedge aclk);
		core.op(1);
		rd(WSC_ADDR_STATUS);
		chk(d, 32'h00000011);
		chk(32'({core_run, main_osc_run}), 32'h0);
		wt_for(0, n);
		chk(32'(n > B / 2 && n <= B && rsts == n0), 32'h1);
		rd(WSC_ADDR_STATUS);
		chk(d, 32'h00000000);
		// Either pin edge polarity for the external source
		wr(WSC_ADDR_OPTION, 8'hBF | 8'($urandom_range(1) << 6));
		// Each wake source, with a disabled one fired first
		for (int s = 0; s < 3; s++)
		begin
			g = $urandom_range(1);
			wr(WSC_ADDR_IRQ, 8'((g << 7) | (16 << s)));
			core.op(1);
			iosv = {io_do, io_oeo};
			fire((s + 1) % 3);
			repeat (3) @(posedge aclk);
			chk(32'(core_run), 32'h0);
			chk(32'({io_do, io_oeo}), 32'(iosv));
			rd(WSC_ADDR_IRQ);
			chk(d & 32'h7, 32'(1 << ((s + 1) % 3)));
			fire(s);
			wt_for(0, n);
			chk(32'(n < 6), 32'h1);
			chk(32'(resume_vector), 32'(g));
		end
		wr(WSC_ADDR_IRQ, 8'h22);
		core.op(1);
		@(posedge aclk);
		chk(32'({core_run, prefetch_req, resume_pulse}), 32'h7);
		fuse <= fuse & 8'hEC;
		wr(WSC_ADDR_IRQ, 8'h20);
		core.op(1);
		fire(1);
		repeat (5) @(posedge aclk);
		chk(32'({core_run, main_osc_run}), 32'h1);
		wt_for(0, n);
		chk(32'(n >= 1015 && n <= 1027), 32'h1);
		wr(WSC_ADDR_IRQ, 8'h00);
		core.op(1);
		n0 = rsts;
		pin_n <= 1'b0;
		repeat (2) @(posedge aclk);
		pin_n <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(32'(rsts > n0 && core_run), 32'h1);
		end_sim();
	end
endmodule : watchdog_sleep_wake_control_bench
`default_nettype wire
